// file: include/status_queue_defines.vh
// constants for the status, alarm flag and result queue block
// assumes one core clock; the serial link is sampled, not clocked on
// Function
// - command F6h reads status, upper nine ignored
// - restart bit set by resets, cleared by read
// - bit 5 shows other arithmetic work busy
// - bit 4 shows sense calibration busy
// - bit 3 converter, alarm check or sample store busy
// - bit 2 shows table lookup or code busy
// - bit 1 is queue empty, clear empties queue
// - sample mode overflow sticky until read or clear
// - table mode bit 0 is live full
// - command F8h reads alarm flags, then clears them
// - channel two flags in bits 11 to 6
// - channel one flags in bits 5 to 0
// - queue holds 15 samples or 16 words
// - entries carry source tag plus result bits
// - full sample queue drops the oldest entry
// - command 80h shifts out the oldest entry
// - store enable gates samples into the queue
// - empty read returns tag 1111 and status
// - full collision read returns tag 1110
// - table copy pauses while queue is full
// - reads and arrivals may share one cycle
`ifndef STATUS_QUEUE_DEFINES_VH
`define STATUS_QUEUE_DEFINES_VH

// command bytes
`define CMD_STATUS_READ 8'hF6
`define CMD_ALARM_READ 8'hF8
`define CMD_QUEUE_READ 8'h80
`define CMD_TABLE_READ 8'hFC

// general status bit positions
`define ST_RESTART 6
`define ST_ARITH_BUSY 5
`define ST_SENSE_BUSY 4
`define ST_CONV_BUSY 3
`define ST_GATE_BUSY 2
`define ST_EMPTY 1
`define ST_OVERFLOW 0

// reset values of the live busy bits
`define RST_GATE_BUSY 1'b1
`define RST_OTHER_BUSY 1'b0

// queue sizes and tags
`define QUEUE_WIDTH 16
`define QUEUE_DEPTH 16
`define QUEUE_ADDR 4
`define SAMPLE_LIMIT 5'h0F
`define TAG_EMPTY 4'hF
`define TAG_COLLIDE 4'hE
`define ALARM_BITS 12

// serial frame bit counts
`define CMD_BITS 5'h08
`define FRAME_BITS 5'h18

`endif

// file: rtl/tagged_queue.v
// first-in first-out store for tagged 16-bit result words
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ns
module tagged_queue #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter ADDR = 4
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire clear_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [ADDR:0] count_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR-1:0] wr_ptr_reg;
  reg [ADDR-1:0] rd_ptr_reg;
  reg [ADDR:0] count_reg;
  wire push;
  wire pop;

  // handshakes; ready only while a slot is free
  assign in_ready_out = (count_reg != DEPTH[ADDR:0]);
  assign out_valid_out = (count_reg != {(ADDR+1){1'b0}});
  assign out_data_out = mem[rd_ptr_reg];
  assign count_out = count_reg;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // storage write
  always @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers and fill count; push and pop may share a cycle
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= {ADDR{1'b0}};
      rd_ptr_reg <= {ADDR{1'b0}};
      count_reg <= {(ADDR+1){1'b0}};
    end else if (ce_in) begin
      if (clear_in) begin
        wr_ptr_reg <= {ADDR{1'b0}};
        rd_ptr_reg <= {ADDR{1'b0}};
        count_reg <= {(ADDR+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + {{(ADDR-1){1'b0}}, 1'b1};
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_reg + {{(ADDR-1){1'b0}}, 1'b1};
        end
        if (push && !pop) begin
          count_reg <= count_reg + {{ADDR{1'b0}}, 1'b1};
        end else if (pop && !push) begin
          count_reg <= count_reg - {{ADDR{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // tagged_queue

// file: rtl/status_alarm_flags_fifo.v
// status register, alarm flags and result queue behind a serial port
// assumes serial clock, select and data in come from pins (sampled here);
// busy levels, alarm events, samples and table words come from core logic
`timescale 1ns/1ns
`include "status_queue_defines.vh"
module status_alarm_flags_fifo #(
  parameter WIDTH = `QUEUE_WIDTH,
  parameter DEPTH = `QUEUE_DEPTH,
  parameter ADDR = `QUEUE_ADDR
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire ce_in,
  // serial port pins
  input wire sclk_in,
  input wire cs_n_in,
  input wire sdi_in,
  output reg sdo_out,
  output reg sdo_oe_n_out,
  // reset causes and software clear strobes
  input wire watchdog_reset_in,
  input wire full_reset_in,
  input wire queue_clear_in,
  input wire alarm_clear_in,
  // busy sources
  input wire arith_other_busy_in,
  input wire sense_cal_busy_in,
  input wire converter_busy_in,
  input wire alarm_check_busy_in,
  input wire gate_code_busy_in,
  // alarm threshold crossings, one pulse per flag
  input wire [11:0] alarm_set_in,
  // converter samples
  input wire sample_store_enable_in,
  input wire sample_valid_in,
  input wire [3:0] sample_tag_in,
  input wire [11:0] sample_data_in,
  // lookup-table words, tag already in the upper bits
  input wire table_valid_in,
  input wire [15:0] table_word_in,
  output reg table_ready_out,
  output reg table_start_out,
  output reg queue_empty_out
);
  // pin synchronisers and edge tracking
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg sclk_last_reg;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_active;

  // serial frame state
  reg [4:0] bit_cnt_reg;
  reg [7:0] cmd_shift_reg;
  reg [15:0] tx_reg;
  wire [7:0] cmd_byte;
  wire cmd_done;

  // flags and mode
  reg restart_reg;
  reg overflow_reg;
  reg table_mode_reg;
  reg arith_busy_reg;
  reg sense_busy_reg;
  reg conv_busy_reg;
  reg gate_busy_reg;
  reg [11:0] alarm_reg;
  reg [11:0] alarm_next;
  reg restart_next;
  reg overflow_next;

  // queue wiring
  wire q_in_ready;
  wire q_out_valid;
  wire [15:0] q_out_data;
  wire [ADDR:0] q_count;
  wire [15:0] q_in_data;
  wire q_in_valid;
  wire q_pop;
  wire conv_push;
  wire table_push;
  wire host_pop;
  wire discard;
  wire collide;
  wire [ADDR:0] count_next;
  wire [15:0] status_word;
  wire [15:0] read_word;

  // two flip-flops on every pin before any logic reads it
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sclk_sync_reg <= 2'b00;
      cs_sync_reg <= 2'b11;
      sdi_sync_reg <= 2'b00;
      sclk_last_reg <= 1'b0;
    end else if (ce_in) begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi_in};
      sclk_last_reg <= sclk_sync_reg[1];
    end
  end

  // edges of the sampled serial clock, only inside a selected frame
  assign cs_active = ~cs_sync_reg[1];
  assign sclk_rise = cs_active & sclk_sync_reg[1] & ~sclk_last_reg;
  assign sclk_fall = cs_active & ~sclk_sync_reg[1] & sclk_last_reg;
  assign cmd_byte = {cmd_shift_reg[6:0], sdi_sync_reg[1]};
  assign cmd_done = sclk_rise & (bit_cnt_reg == `CMD_BITS - 5'h01);

  // status word; upper nine bits read as zero
  assign status_word[15:7] = 9'h000;
  assign status_word[`ST_RESTART] = restart_reg;
  assign status_word[`ST_ARITH_BUSY] = arith_busy_reg;
  assign status_word[`ST_SENSE_BUSY] = sense_busy_reg;
  assign status_word[`ST_CONV_BUSY] = conv_busy_reg;
  assign status_word[`ST_GATE_BUSY] = gate_busy_reg;
  assign status_word[`ST_EMPTY] = ~q_out_valid;
  // overflow bit: sticky in sample mode, live full in table mode
  assign status_word[`ST_OVERFLOW] = table_mode_reg ?
    (q_count == DEPTH[ADDR:0]) : overflow_reg;

  // queue pushes: samples only with store enable and outside table mode
  assign conv_push = sample_valid_in & sample_store_enable_in & ~table_mode_reg;
  // table words wait while the queue is full
  assign table_push = table_valid_in & table_mode_reg & table_ready_out & q_in_ready;
  assign q_in_valid = conv_push | table_push;
  assign q_in_data = conv_push ? {sample_tag_in, sample_data_in} : table_word_in;

  // host read of the oldest entry pops on the command's last bit
  assign host_pop = cmd_done & (cmd_byte == `CMD_QUEUE_READ) & q_out_valid;
  // sample at the limit with no read: drop oldest to keep newest 15
  assign discard = conv_push & ~host_pop & (q_count >= `SAMPLE_LIMIT);
  // sample at the limit landing with a read: flag the returned item
  assign collide = conv_push & host_pop & (q_count >= `SAMPLE_LIMIT);
  assign q_pop = host_pop | discard;

  // word loaded for shifting out after a read command
  assign read_word = (cmd_byte == `CMD_STATUS_READ) ? status_word :
    (cmd_byte == `CMD_ALARM_READ) ? {4'h0, alarm_reg} :
    (cmd_byte != `CMD_QUEUE_READ) ? 16'h0000 :
    ~q_out_valid ? {`TAG_EMPTY, status_word[11:0]} :
    collide ? {`TAG_COLLIDE, q_out_data[11:0]} :
    q_out_data;

  // fill count after this cycle, used for the registered ready
  assign count_next = queue_clear_in ? {(ADDR+1){1'b0}} :
    q_count + {{ADDR{1'b0}}, q_in_valid & (q_in_ready | q_pop)} -
    {{ADDR{1'b0}}, q_pop & q_out_valid};

  tagged_queue #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .ADDR(ADDR)
  ) u_queue (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .clear_in(queue_clear_in),
    .in_valid_in(q_in_valid),
    .in_ready_out(q_in_ready),
    .in_data_in(q_in_data),
    .out_valid_out(q_out_valid),
    .out_ready_in(q_pop),
    .out_data_out(q_out_data),
    .count_out(q_count)
  );

  // serial frame: command in on rising edges, data out on falling edges
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      bit_cnt_reg <= 5'h00;
      cmd_shift_reg <= 8'h00;
      tx_reg <= 16'h0000;
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      sdo_oe_n_out <= ~cs_active; // low while driving
      if (!cs_active) begin
        bit_cnt_reg <= 5'h00;
        tx_reg <= 16'h0000;
        sdo_out <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt_reg != `FRAME_BITS) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          cmd_shift_reg <= cmd_byte;
        end
        if (cmd_done) begin
          tx_reg <= read_word;
        end else if (sclk_fall && bit_cnt_reg >= `CMD_BITS) begin
          sdo_out <= tx_reg[15]; // msb first
          tx_reg <= {tx_reg[14:0], 1'b0};
        end
      end
    end
  end

  // sticky flag next values; a set in the clearing cycle wins
  always @* begin
    restart_next = restart_reg;
    overflow_next = overflow_reg;
    alarm_next = alarm_reg;
    if (cmd_done && cmd_byte == `CMD_STATUS_READ) begin
      restart_next = 1'b0;
      overflow_next = 1'b0;
    end
    if (queue_clear_in) begin
      overflow_next = 1'b0;
    end
    if ((cmd_done && cmd_byte == `CMD_ALARM_READ) || alarm_clear_in) begin
      alarm_next = 12'h000;
    end
    if (watchdog_reset_in || full_reset_in) begin
      restart_next = 1'b1;
    end
    if (discard) begin
      overflow_next = 1'b1;
    end
    alarm_next = alarm_next | alarm_set_in;
  end

  // flag registers, busy sampling and table mode
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      restart_reg <= 1'b0;
      overflow_reg <= 1'b0;
      alarm_reg <= 12'h000;
      arith_busy_reg <= `RST_OTHER_BUSY;
      sense_busy_reg <= `RST_OTHER_BUSY;
      conv_busy_reg <= `RST_OTHER_BUSY;
      gate_busy_reg <= `RST_GATE_BUSY;
      table_mode_reg <= 1'b0;
      table_start_out <= 1'b0;
      table_ready_out <= 1'b0;
      queue_empty_out <= 1'b1;
    end else if (ce_in) begin
      restart_reg <= restart_next;
      overflow_reg <= overflow_next;
      alarm_reg <= alarm_next;
      arith_busy_reg <= arith_other_busy_in;
      sense_busy_reg <= sense_cal_busy_in;
      // converting, checking alarms or storing a sample in the queue
      conv_busy_reg <= converter_busy_in | alarm_check_busy_in | conv_push;
      gate_busy_reg <= gate_code_busy_in;
      table_start_out <= cmd_done & (cmd_byte == `CMD_TABLE_READ);
      if (queue_clear_in) begin
        table_mode_reg <= 1'b0;
      end else if (cmd_done && cmd_byte == `CMD_TABLE_READ) begin
        table_mode_reg <= 1'b1;
      end
      // ready reflects free space after this cycle, except in a clearing cycle
      table_ready_out <= (count_next != DEPTH[ADDR:0]) & ~queue_clear_in;
      queue_empty_out <= (count_next == {(ADDR+1){1'b0}});
    end
  end
endmodule // status_alarm_flags_fifo

// file: test/status_alarm_flags_fifo_sva.sv
// checker for the status, alarm flag and result queue block
// assumes bind to the top module; ports are watched, never driven
`timescale 1ns/1ns
module status_alarm_flags_fifo_sva (
  input wire core_clk_in,
  input wire nrst_in,
  input wire cs_n_in,
  input wire queue_clear_in,
  input wire sample_valid_in,
  input wire sample_store_enable_in,
  input wire table_valid_in,
  input wire table_ready_out,
  input wire table_start_out,
  input wire queue_empty_out,
  input wire sdo_oe_n_out
);
  logic tmode_reg;
  // table mode: entered by the start pulse, left on a queue clear
  always @(posedge core_clk_in) begin
    if (!nrst_in || queue_clear_in)
      tmode_reg <= 1'b0;
    else if (table_start_out)
      tmode_reg <= 1'b1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_start_single_pulse: assert property (table_start_out |=> !table_start_out)
    else $error("table start pulse longer than one cycle");
  a_oe_idle_high: assert property (cs_n_in [*5] |-> sdo_oe_n_out)
    else $error("data output driven while not selected");
  a_oe_frame_low: assert property (!cs_n_in [*5] |-> !sdo_oe_n_out)
    else $error("data output not driven while selected");
  a_clear_empties: assert property (queue_clear_in && !sample_valid_in && !table_valid_in
    |=> ##[0:1] queue_empty_out)
    else $error("queue not empty after clear");
  a_sample_fills: assert property (sample_valid_in && sample_store_enable_in && !tmode_reg
    && !queue_clear_in && cs_n_in && $past(cs_n_in, 4) |-> ##[1:2] !queue_empty_out)
    else $error("stored sample left queue empty");
  a_empty_cause: assert property ($fell(queue_empty_out) |-> $past(sample_valid_in)
    || $past(sample_valid_in, 2) || $past(table_valid_in) || $past(table_valid_in, 2))
    else $error("empty flag fell without an arrival");
  a_ready_release: assert property ($rose(nrst_in) |=> table_ready_out)
    else $error("table ready missing after reset");
  a_ready_clear_low: assert property (queue_clear_in |=> !table_ready_out)
    else $error("table ready high while clearing");
endmodule // status_alarm_flags_fifo_sva

// file: test/serial_host_model.sv
// behavioural serial host: select, clock and data out, answer sampled in
// assumes the device changes its data output after each serial clock fall
`timescale 1ns/1ns
module serial_host_model #(
  parameter HALF = 80
) (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire sdo_in
);
  // idle: clock stands low, select high
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b1;
  end
  // one frame: 8 command bits out, then 16 answer bits in, msb first
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] rx);
    logic [23:0] tx;
    tx = {cmd, 16'h0000};
    rx = 16'h0000;
    cs_n_out = 1'b0;
    #HALF;
    for (int i = 23; i >= 0; i--) begin
      sdi_out = tx[i];
      #HALF sclk_out = 1'b1;
      if (i < 16)
        rx[i] = sdo_in;
      #HALF sclk_out = 1'b0;
    end
    #HALF cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // released line shows no stale value
    #(2*HALF);
  endtask
endmodule // serial_host_model

// file: test/status_alarm_flags_fifo_tb_top.sv
// testbench for the status, alarm flag and result queue block
// assumes the serial host model and the checker compiled alongside
`timescale 1ns/1ns
module status_alarm_flags_fifo_tb_top;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wd_rst = 0, full_rst = 0, q_clr = 0, a_clr = 0;
  logic [4:0] busy_v = 5'h00;
  logic [11:0] alarm_set = 12'h000;
  logic store_en = 1, s_valid = 0, t_valid = 0;
  logic [3:0] s_tag = 4'h0;
  logic [11:0] s_data = 12'h000;
  logic [15:0] t_word = 16'h0000, rx;
  wire sclk, cs_n, sdi, sdo, sdo_oe_n, table_ready, table_start, queue_empty;
  int n_fail = 0, checks_done = 0;
  int bpos[5] = '{2, 3, 3, 4, 5};
  // core clock, 4 ns period
  always #2 core_clk_in = ~core_clk_in;
  status_alarm_flags_fifo status_alarm_flags_fifo_i (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .watchdog_reset_in(wd_rst),
    .full_reset_in(full_rst), .queue_clear_in(q_clr), .alarm_clear_in(a_clr),
    .arith_other_busy_in(busy_v[4]), .sense_cal_busy_in(busy_v[3]),
    .converter_busy_in(busy_v[2]), .alarm_check_busy_in(busy_v[1]),
    .gate_code_busy_in(busy_v[0]), .alarm_set_in(alarm_set),
    .sample_store_enable_in(store_en), .sample_valid_in(s_valid), .sample_tag_in(s_tag),
    .sample_data_in(s_data), .table_valid_in(t_valid), .table_word_in(t_word),
    .table_ready_out(table_ready), .table_start_out(table_start),
    .queue_empty_out(queue_empty));
  serial_host_model serial_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo));
  task tick;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic read(input logic [7:0] cmd, input logic [15:0] exp);
    serial_host_model_i.xfer(cmd, rx);
    check(rx, exp);
  endtask
  task automatic push(input logic [15:0] w);
    t_word = w;
    t_valid = 1;
    for (int n = 0; n < 4000 && table_ready !== 1'b1; n++)
      tick;
    check({15'h0000, table_ready}, 16'h0001);
    tick;
  endtask
  task t_status;
    read(8'hF6, 16'h0002);
    check({15'h0000, sdo_oe_n}, 16'h0001);
    tick; wd_rst = 1; tick; wd_rst = 0;
    read(8'hF6, 16'h0042);
    read(8'hF6, 16'h0002);
    tick; full_rst = 1; tick; full_rst = 0;
    read(8'hF6, 16'h0042);
    for (int i = 0; i < 5; i++) begin
      tick; busy_v = 5'h01 << i;
      read(8'hF6, 16'h0002 | (16'h0001 << bpos[i]));
    end
    tick; busy_v = 5'h00;
  endtask
  task t_alarm;
    tick; alarm_set = 12'hA5C; tick; alarm_set = 12'h000;
    read(8'hF8, 16'h0A5C);
    tick; alarm_set = 12'h5A3; tick; alarm_set = 12'h000;
    read(8'hF8, 16'h05A3);
    tick; alarm_set = 12'h801; a_clr = 1; tick; alarm_set = 12'h000; a_clr = 0;
    read(8'hF8, 16'h0801);
    tick; alarm_set = 12'hFFF; tick; alarm_set = 12'h000; a_clr = 1; tick; a_clr = 0;
    read(8'hF8, 16'h0000);
  endtask
  task t_samples;
    for (int i = 0; i < 17; i++) begin
      tick; s_valid = 1; s_tag = i[3:0]; s_data = 12'h100 + i[11:0];
    end
    tick; s_valid = 0;
    check({15'h0000, queue_empty}, 16'h0000);
    for (int i = 2; i < 17; i++)
      read(8'h80, {i[3:0], 12'h100 + i[11:0]});
    read(8'hF6, 16'h0003);
    read(8'hF6, 16'h0002);
    read(8'h80, 16'hF002);
    tick; store_en = 0; s_valid = 1; tick; s_valid = 0; store_en = 1;
    read(8'h80, 16'hF002);
    // samples every cycle keep the queue full, so the read collides
    tick; s_tag = 4'h3; s_data = 12'h777; s_valid = 1;
    read(8'h80, 16'hE777);
    tick; s_valid = 0;
    read(8'h80, 16'h3777);
    tick; q_clr = 1; tick; q_clr = 0;
    read(8'hF6, 16'h0002);
  endtask
  task t_table;
    read(8'hFC, 16'h0000);
    for (int i = 0; i < 16; i++)
      push(16'hC000 + i[15:0]);
    t_word = 16'hC010; repeat (4) tick;
    check({15'h0000, table_ready}, 16'h0000);
    read(8'hF6, 16'h0001);
    read(8'h80, 16'hC000);
    t_valid = 0;
    check({15'h0000, table_ready}, 16'h0000);
    read(8'hF6, 16'h0001);
    for (int i = 1; i < 17; i++)
      read(8'h80, 16'hC000 + i[15:0]);
    read(8'hF6, 16'h0002);
    push(16'hC0AA);
    t_valid = 0; tick; q_clr = 1; tick; q_clr = 0;
    read(8'hF6, 16'h0002);
    read(8'h80, 16'hF002);
  endtask
  task give_verdict;
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence: reset, then each scenario in turn
  initial begin
    repeat (2) @(posedge core_clk_in);
    #1 nrst_in = 1;
    repeat (4) tick;
    t_status;
    t_alarm;
    t_samples;
    t_table;
    give_verdict;
  end
  // watchdog: about one and a half times the expected run
  initial begin
    #360000;
    n_fail++;
    give_verdict;
  end
endmodule // status_alarm_flags_fifo_tb_top
bind status_alarm_flags_fifo status_alarm_flags_fifo_sva status_alarm_flags_fifo_sva_i (
  .core_clk_in, .nrst_in, .cs_n_in, .queue_clear_in, .sample_valid_in,
  .sample_store_enable_in, .table_valid_in, .table_ready_out, .table_start_out,
  .queue_empty_out, .sdo_oe_n_out);
